// ---- verilog/sdpc_pkg.sv ----
package sdpc_pkg;
  localparam logic [5:0] SDPC_SPACE_CODE = 6'h01;
  localparam int SDPC_SPACE_HI = 31;
  localparam int SDPC_SPACE_LO = 26;
  localparam int SDPC_A10_BIT = 10;
  localparam logic [2:0] SDPC_OP_NONE = 3'h0;
  localparam logic [2:0] SDPC_OP_ACT = 3'h1;
  localparam logic [2:0] SDPC_OP_READ = 3'h2;
  localparam logic [2:0] SDPC_OP_WRITE = 3'h3;
  localparam logic [2:0] SDPC_OP_PRE = 3'h4;
  localparam logic [2:0] SDPC_OP_REF = 3'h5;
  localparam logic [2:0] SDPC_OP_MRS = 3'h6;
  localparam logic [2:0] SDPC_OP_SELF = 3'h7;

  typedef struct packed {
    logic [2:0] op;
    logic [31:0] addr;
    logic word_acc;
    logic a10;
  } sdpc_cmd_t;

  typedef struct packed {
    logic select_n;
    logic ras_n;
    logic cas_n;
    logic write_strobe_n;
    logic low_mask;
    logic high_mask;
    logic a10;
    logic clk_gate;
  } sdpc_pins_t;

  localparam sdpc_pins_t SDPC_PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
endpackage

// ---- verilog/sdpc_pin_control.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Select asserted on commands in SDRAM space
// - Only bus master drives select
// - Row strobe low marks row address
// - Column strobe low marks column address
// - Write strobe low write, high read
// - Low mask only with column, never reads
// - Low mask on odd word, 64-bit writes
// - High mask only with column, never reads
// - High mask on even word or 32-bit
// - Dedicated address bit 10 output
// - Clock gate low for self-refresh/suspend
// - Self-refresh and float pins before grant
module sdpc_pin_control #(
  parameter int SPACE_HI = sdpc_pkg::SDPC_SPACE_HI,
  parameter int SPACE_LO = sdpc_pkg::SDPC_SPACE_LO
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire sdpc_pkg::sdpc_cmd_t cmd,
  input wire logic bus_master,
  input wire logic bus_64bit,
  input wire logic suspend_req,
  input wire logic host_request_line,
  output sdpc_pkg::sdpc_pins_t pins_out,
  output logic pins_oe,
  output logic host_grant_ack
);
  import sdpc_pkg::*;

  // Space code is six bits; any other span could never match it
  if (SPACE_HI - SPACE_LO != 5 || SPACE_HI > 31 || SPACE_LO < 0) begin : g_bad_space
    $error("space field must be six bits inside the address");
  end

  typedef enum logic [1:0] {
    SDPC_RUN = 2'b00,
    SDPC_ENTER_SELF = 2'b01,
    SDPC_GRANTED = 2'b10
  } sdpc_state_t;

  sdpc_state_t state_reg;
  sdpc_pins_t pins_reg;
  sdpc_pins_t pins_next;
  logic oe_reg;
  logic grant_reg;

  function automatic logic in_space(input logic [31:0] a);
    in_space = (a[SPACE_HI:SPACE_LO] == SDPC_SPACE_CODE);
  endfunction

  // Row, column and write strobe levels for one command
  function automatic logic [2:0] cmd_code(input logic [2:0] op);
    case (op)
      SDPC_OP_ACT: cmd_code = 3'h3;
      SDPC_OP_READ: cmd_code = 3'h5;
      SDPC_OP_WRITE: cmd_code = 3'h4;
      SDPC_OP_PRE: cmd_code = 3'h2;
      SDPC_OP_REF: cmd_code = 3'h1;
      SDPC_OP_MRS: cmd_code = 3'h0;
      SDPC_OP_SELF: cmd_code = 3'h1;
      default: cmd_code = 3'h7;
    endcase
  endfunction

  // Low then high mask of a write; kept apart from the command decode
  function automatic logic [1:0] write_masks(input logic wide, input logic word,
                                             input logic odd);
    write_masks[1] = wide && word && odd;
    write_masks[0] = !wide || (word && !odd);
  endfunction

  // Issue only while master and not handing off
  logic issue;
  assign issue = cmd_valid && bus_master && state_reg == SDPC_RUN && !host_request_line &&
    in_space(cmd.addr);

  always_comb begin
    pins_next = SDPC_PINS_IDLE;
    pins_next.clk_gate = !suspend_req;
    pins_next.a10 = cmd.a10;
    if (state_reg != SDPC_RUN) begin
      pins_next.clk_gate = 1'b0;
      pins_next.a10 = 1'b0;
    end else if (issue) begin
      pins_next.select_n = 1'b0;
      case (cmd.op)
        SDPC_OP_ACT: begin
          pins_next.ras_n = 1'b0;
          pins_next.a10 = cmd.a10;
        end
        SDPC_OP_READ: begin
          pins_next.cas_n = 1'b0;
          pins_next.write_strobe_n = 1'b1;
        end
        SDPC_OP_WRITE: begin
          pins_next.cas_n = 1'b0;
          pins_next.write_strobe_n = 1'b0;
          pins_next.low_mask = bus_64bit && cmd.word_acc && cmd.addr[0];
          pins_next.high_mask = !bus_64bit || (cmd.word_acc && !cmd.addr[0]);
        end
        SDPC_OP_PRE: begin
          pins_next.ras_n = 1'b0;
          pins_next.write_strobe_n = 1'b0;
        end
        SDPC_OP_REF: begin
          pins_next.ras_n = 1'b0;
          pins_next.cas_n = 1'b0;
        end
        SDPC_OP_MRS: begin
          pins_next.ras_n = 1'b0;
          pins_next.cas_n = 1'b0;
          pins_next.write_strobe_n = 1'b0;
        end
        SDPC_OP_SELF: begin
          pins_next.ras_n = 1'b0;
          pins_next.cas_n = 1'b0;
          pins_next.clk_gate = 1'b0;
        end
        default: pins_next.select_n = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pins_reg <= SDPC_PINS_IDLE;
    end else begin
      pins_reg <= pins_next;
    end
  end

  // Handoff: self-refresh entry, then float, then grant
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SDPC_RUN;
    end else begin
      case (state_reg)
        SDPC_RUN: if (host_request_line && bus_master) state_reg <= SDPC_ENTER_SELF;
        SDPC_ENTER_SELF: state_reg <= SDPC_GRANTED;
        SDPC_GRANTED: if (!host_request_line) state_reg <= SDPC_RUN;
        default: state_reg <= SDPC_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      oe_reg <= 1'b0;
      grant_reg <= 1'b0;
    end else begin
      oe_reg <= bus_master && state_reg == SDPC_RUN && !host_request_line;
      grant_reg <= state_reg == SDPC_GRANTED && host_request_line;
    end
  end

  // Self-refresh entry cycle also drives the command
  sdpc_pins_t self_cmd;
  always_comb begin
    self_cmd = pins_reg;
    if (state_reg == SDPC_ENTER_SELF) begin
      self_cmd = SDPC_PINS_IDLE;
      self_cmd.select_n = 1'b0;
      {self_cmd.ras_n, self_cmd.cas_n, self_cmd.write_strobe_n} = cmd_code(SDPC_OP_SELF);
      self_cmd.clk_gate = 1'b0;
    end
  end

  assign pins_out = self_cmd;
  assign pins_oe = oe_reg || state_reg == SDPC_ENTER_SELF;
  assign host_grant_ack = grant_reg;

  // Masks only qualify a write column cycle
  read_masks_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (pins_reg.cas_n || pins_reg.write_strobe_n) |-> (!pins_reg.low_mask && !pins_reg.high_mask))
    else $error("mask active outside write");

  read_nomask_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_READ |=> !pins_reg.low_mask && !pins_reg.high_mask)
    else $error("mask active on read");

  write_col_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_WRITE |=> !pins_reg.cas_n && !pins_reg.write_strobe_n)
    else $error("write not encoded");

  read_col_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_READ |=> !pins_reg.cas_n && pins_reg.write_strobe_n && pins_reg.ras_n)
    else $error("read not encoded");

  act_row_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_ACT |=> !pins_reg.ras_n && pins_reg.cas_n)
    else $error("activate not encoded");

  // Independent decode: the command case above must agree with the table
  enc_all_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op != SDPC_OP_NONE |=> !pins_reg.select_n &&
    {pins_reg.ras_n, pins_reg.cas_n, pins_reg.write_strobe_n} == cmd_code($past(cmd.op)))
    else $error("command not encoded");

  none_nop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_NONE |=> pins_reg.select_n &&
    {pins_reg.ras_n, pins_reg.cas_n, pins_reg.write_strobe_n} == 3'h7)
    else $error("empty command not idle");

  space_sel_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cmd_valid && !in_space(cmd.addr) |=> pins_reg.select_n)
    else $error("select outside space");

  master_only_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !bus_master |=> !oe_reg)
    else $error("slave drives pins");

  slave_pins_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !bus_master && state_reg == SDPC_RUN |=> pins_reg.select_n && !pins_oe)
    else $error("slave issues command");

  mask_32_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_WRITE && !bus_64bit |=> pins_reg.high_mask && !pins_reg.low_mask)
    else $error("32-bit mask wrong");

  mask_odd_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_WRITE && bus_64bit && cmd.word_acc && cmd.addr[0]
    |=> pins_reg.low_mask && !pins_reg.high_mask)
    else $error("odd word mask wrong");

  write_mask_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_WRITE |=> {pins_reg.low_mask, pins_reg.high_mask} ==
    $past(write_masks(bus_64bit, cmd.word_acc, cmd.addr[0])))
    else $error("write mask pair wrong");

  word_none_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_WRITE && bus_64bit && !cmd.word_acc
    |=> !pins_reg.low_mask && !pins_reg.high_mask)
    else $error("wide access masked");

  a10_pass_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == SDPC_RUN && !issue |=> pins_reg.a10 == $past(cmd.a10))
    else $error("a10 not passed");

  act_a10_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_ACT |=> pins_reg.a10 == $past(cmd.a10))
    else $error("a10 lost on activate");

  a10_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg != SDPC_RUN |=> !pins_reg.a10)
    else $error("a10 high while handed off");

  clk_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    suspend_req |=> !pins_reg.clk_gate)
    else $error("clock gate high in suspend");

  gate_run_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == SDPC_RUN && !suspend_req && !(issue && cmd.op == SDPC_OP_SELF)
    |=> pins_reg.clk_gate)
    else $error("clock gate low while running");

  self_enc_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    issue && cmd.op == SDPC_OP_SELF |=> !pins_reg.clk_gate &&
    {pins_reg.ras_n, pins_reg.cas_n, pins_reg.write_strobe_n} == cmd_code(SDPC_OP_SELF))
    else $error("self-refresh not encoded");

  sequence handoff_s;
    state_reg == SDPC_ENTER_SELF ##1 state_reg == SDPC_GRANTED;
  endsequence

  // Host leaves, grant drops, then pins come back one cycle later
  sequence return_s;
    state_reg == SDPC_GRANTED && !host_request_line ##1 !host_request_line && bus_master;
  endsequence

  grant_order_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(host_grant_ack) |-> !pins_oe && $past(state_reg == SDPC_GRANTED))
    else $error("grant before float");

  handoff_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == SDPC_RUN && host_request_line && bus_master |=> handoff_s)
    else $error("handoff skipped self-refresh");

  entry_pins_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == SDPC_ENTER_SELF |-> pins_oe && !pins_out.select_n && !pins_out.clk_gate &&
    {pins_out.ras_n, pins_out.cas_n, pins_out.write_strobe_n} == cmd_code(SDPC_OP_SELF))
    else $error("entry cycle not self-refresh");

  float_grant_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == SDPC_GRANTED |-> !pins_oe)
    else $error("pins driven while granted");

  grant_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    host_grant_ack && host_request_line |=> host_grant_ack)
    else $error("grant dropped early");

  grant_drop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    host_grant_ack && !host_request_line |=> !host_grant_ack)
    else $error("grant held after request");

  grant_low_run_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == SDPC_RUN |-> !host_grant_ack)
    else $error("grant while running");

  release_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    return_s |-> !host_grant_ack ##1 pins_oe)
    else $error("bus not taken back");

  nop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !cmd_valid && state_reg == SDPC_RUN |=> pins_reg.select_n && pins_reg.ras_n && pins_reg.cas_n)
    else $error("no-op not idle");
endmodule

// ---- tb/sdpc_sdram_model.sv ----
`timescale 1ns/1ps
module sdpc_sdram_model (
  input wire sdpc_pkg::sdpc_pins_t pins,
  input wire logic oe,
  output sdpc_pkg::sdpc_pins_t seen
);
  import sdpc_pkg::*;
  // Released lines settle at their pull-ups, never at the last driven value
  assign seen = oe ? pins : '1;
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import sdpc_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic bus_master = 1'b1;
  logic bus_64bit = 1'b1;
  logic suspend_req = 1'b0;
  logic host_request_line = 1'b0;
  logic pins_oe;
  logic host_grant_ack;
  sdpc_cmd_t cmd = '0;
  sdpc_pins_t pins_out;
  sdpc_pins_t seen;
  int n_fail = 0;
  int n_compared = 0;

  always #50 clk_sys = ~clk_sys;

  sdpc_pin_control u_sdpc_pin_control (.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd(cmd), .bus_master(bus_master), .bus_64bit(bus_64bit), .suspend_req(suspend_req),
    .host_request_line(host_request_line), .pins_out(pins_out), .pins_oe(pins_oe),
    .host_grant_ack(host_grant_ack));
  sdpc_sdram_model u_sdpc_sdram_model (.pins(pins_out), .oe(pins_oe), .seen(seen));

  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Expected order: select, row, column, write strobe, low mask, high mask
  task automatic issue(input logic [2:0] op, input logic [31:0] a, input logic w,
                       input logic [5:0] exp);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= '{op, a, w, 1'b1};
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd <= '0;
    #1;
    check("cmd pins", {2'h0, seen[7:2]}, {2'h0, exp});
    check("a10 gate", {6'h0, seen.a10, seen.clk_gate}, {6'h0, 1'b1, op != SDPC_OP_SELF});
  endtask

  task automatic t_cmds;
    issue(SDPC_OP_ACT, 32'h0400_0000, 1'b1, 6'b001100);
    issue(SDPC_OP_READ, 32'h0400_0001, 1'b1, 6'b010100);
    issue(SDPC_OP_WRITE, 32'h0400_0001, 1'b1, 6'b010010);
    issue(SDPC_OP_WRITE, 32'h0400_0000, 1'b1, 6'b010001);
    issue(SDPC_OP_WRITE, 32'h0400_0001, 1'b0, 6'b010000);
    issue(SDPC_OP_PRE, 32'h0400_0000, 1'b0, 6'b001000);
    issue(SDPC_OP_REF, 32'h0400_0000, 1'b0, 6'b000100);
    issue(SDPC_OP_MRS, 32'h0400_0000, 1'b0, 6'b000000);
    issue(SDPC_OP_SELF, 32'h0400_0000, 1'b0, 6'b000100);
    issue(SDPC_OP_WRITE, 32'h0800_0004, 1'b1, 6'b111100);
    issue(SDPC_OP_NONE, 32'h0400_0000, 1'b1, 6'b111100);
    @(posedge clk_sys);
    bus_64bit <= 1'b0;
    issue(SDPC_OP_WRITE, 32'h0400_0001, 1'b1, 6'b010001);
    @(posedge clk_sys);
    bus_64bit <= 1'b1;
  endtask

  task automatic t_suspend;
    @(posedge clk_sys);
    suspend_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check("gate in suspend", {7'h0, seen.clk_gate}, 8'h00);
    @(posedge clk_sys);
    suspend_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check("gate after suspend", {7'h0, seen.clk_gate}, 8'h01);
  endtask

  task automatic t_slave;
    @(posedge clk_sys);
    bus_master <= 1'b0;
    repeat (2) @(posedge clk_sys);
    issue(SDPC_OP_WRITE, 32'h0400_0000, 1'b1, 6'b111111);
    check("slave oe", {7'h0, pins_oe}, 8'h00);
    @(posedge clk_sys);
    bus_master <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic t_handoff;
    @(posedge clk_sys);
    host_request_line <= 1'b1;
    @(posedge clk_sys);
    #1 check("entry", {pins_oe, pins_out.select_n, pins_out.ras_n, pins_out.cas_n,
                       pins_out.clk_gate, host_grant_ack}, 8'h20);
    @(posedge clk_sys);
    #1 check("float", {pins_oe, host_grant_ack}, 8'h00);
    @(posedge clk_sys);
    #1 check("grant", {pins_oe, host_grant_ack}, 8'h01);
    @(posedge clk_sys);
    host_request_line <= 1'b0;
    @(posedge clk_sys);
    #1 check("grant drop", {pins_oe, host_grant_ack}, 8'h00);
    @(posedge clk_sys);
    #1 check("oe back", {pins_oe, host_grant_ack}, 8'h02);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    #1 check("reset", {pins_oe, host_grant_ack}, 8'h00);
    @(posedge clk_sys);
    nrst <= 1'b1;
    t_cmds;
    t_suspend;
    t_slave;
    t_handoff;
    results;
  end

  initial begin
    #100000;
    n_fail++;
    results;
  end
endmodule
